// *** playback_regs_pkg.sv ***
package playback_regs_pkg;

   // ==========================================================
   // Register offsets on the control port
   localparam logic [15:0] POP_OFS   = 16'h4028; // Pop/click, slew
   localparam logic [15:0] PWR_OFS   = 16'h4029; // Bias, channels
   localparam logic [15:0] DAC_OFS   = 16'h402a; // Mono, pol, enable
   localparam logic [15:0] ATTL_OFS  = 16'h402b; // Left attenuation
   localparam logic [15:0] ATTR_OFS  = 16'h402c; // Right attenuation
   localparam logic [15:0] SPAD_OFS  = 16'h402d; // Audio port pulls
   localparam logic [15:0] CPAD_OFS  = 16'h402f; // Control port pulls
   localparam logic [15:0] DRV_OFS   = 16'h4030; // Control pad drive

   // ==========================================================
   // Reset values
   localparam logic [7:0] POP_RST  = 8'h00;
   localparam logic [7:0] PWR_RST  = 8'h00;
   localparam logic [7:0] DAC_RST  = 8'h00;
   localparam logic [7:0] ATT_RST  = 8'h00;
   localparam logic [7:0] PAD_RST  = 8'haa; // Every pad: no resistor
   localparam logic [7:0] DRV_RST  = 8'h00;

   // ==========================================================
   // Writable bits; the rest are reserved and read as zero
   localparam logic [7:0] POP_WMASK = 8'h1e;
   localparam logic [7:0] DAC_WMASK = 8'he7;
   localparam logic [7:0] DRV_WMASK = 8'h01;

   // ==========================================================
   // Field positions
   localparam int POP_DIS_BIT = 3;
   localparam int SLEW_LSB    = 1;
   localparam int HPB_LSB     = 6;
   localparam int CVB_LSB     = 4;
   localparam int PPB_LSB     = 2;
   localparam int REN_BIT     = 1;
   localparam int LEN_BIT     = 0;
   localparam int MONO_LSB    = 6;
   localparam int POL_BIT     = 5;
   localparam int DEEMPHASIS_ENABLE_BIT   = 2;
   localparam int CEN_LSB     = 0;
   localparam int DRV_BIT     = 0;

   // ==========================================================
   // Field codes
   localparam logic [1:0] SLEW_OFF   = 2'h3;
   localparam logic [1:0] PLAYBACK_PATH_BIAS_SEL_RSVD = 2'h1;
   localparam logic [1:0] PULL_UP    = 2'h0;
   localparam logic [1:0] PULL_DN    = 2'h3;

   // ==========================================================
   // Timing
   localparam real CLK_MHZ  = 200.0;
   localparam real SLEW0_MS = 21.25;
   localparam real SLEW1_MS = 42.5;
   localparam real SLEW2_MS = 85.0;
   localparam int  SLEW0_CYC = int'(SLEW0_MS * 1000.0 * CLK_MHZ);
   localparam int  SLEW1_CYC = int'(SLEW1_MS * 1000.0 * CLK_MHZ);
   localparam int  SLEW2_CYC = int'(SLEW2_MS * 1000.0 * CLK_MHZ);
   localparam int  ATT_STEP_CYC = 16; // Cycles per 0.375 dB step

endpackage : playback_regs_pkg

// *** playback_dac_pad_control_regs.sv ***
`timescale 1ns/10ps

module playback_dac_pad_control_regs #(
   parameter int W            = 24,                         // Sample width
   parameter int SLEW0_CYCLES = playback_regs_pkg::SLEW0_CYC,
   parameter int SLEW1_CYCLES = playback_regs_pkg::SLEW1_CYC,
   parameter int SLEW2_CYCLES = playback_regs_pkg::SLEW2_CYC,
   parameter int ATT_STEP     = playback_regs_pkg::ATT_STEP_CYC
) (
   // Clock, reset, enable
   input  wire logic         clk_i,
   input  wire logic         nrst_i,
   input  wire logic         ce_i,
   // Register port from the control port front end
   input  wire logic [15:0]  reg_addr_i,
   input  wire logic         reg_wr_i,
   input  wire logic [7:0]   reg_wdata_i,
   input  wire logic         reg_rd_i,
   output logic      [7:0]   reg_rdata_o,
   // Playback samples in and out
   input  wire logic [W-1:0] play_l_i,
   input  wire logic [W-1:0] play_r_i,
   input  wire logic         play_valid_i,
   output logic      [W-1:0] out_l_o,
   output logic      [W-1:0] out_r_o,
   output logic              out_valid_o,
   // Analog playback controls
   output logic              pop_suppress_active_o,
   output logic              analog_slew_off_o,
   output logic      [31:0]  analog_ramp_cycles_o,
   output logic      [1:0]   headphone_bias_sel_o,
   output logic      [1:0]   converter_bias_sel_o,
   output logic      [1:0]   playback_path_bias_sel_o,
   output logic              right_play_enable_o,
   output logic              left_play_enable_o,
   // Converter controls
   output logic              left_dac_on_o,
   output logic              right_dac_on_o,
   output logic              mono_on_left_o,
   output logic              mono_on_right_o,
   output logic              deemphasis_enable_o,
   output logic      [7:0]   left_digital_attenuation_o,
   output logic      [7:0]   right_digital_attenuation_o,
   // Pad controls: bit 3 record data, 2 playback data, 1 frame, 0 bit clk
   output logic      [3:0]   audio_pad_pull_up_o,
   output logic      [3:0]   audio_pad_pull_down_o,
   // Pad controls: bit 3 data in, 2 latch, 1 clock, 0 data out
   output logic      [3:0]   ctrl_pad_pull_up_o,
   output logic      [3:0]   ctrl_pad_pull_down_o,
   output logic              ctrl_data_out_drive_high_o
);

   // ==========================================================
   // State
   typedef struct packed {
      logic [7:0]         pop;    // Pop/click and slew register
      logic [7:0]         pwr;    // Playback power register
      logic [7:0]         dac;    // Converter control register
      logic [7:0]         att_l;  // Left attenuation target
      logic [7:0]         att_r;  // Right attenuation target
      logic [7:0]         spad;   // Audio port pad pulls
      logic [7:0]         cpad;   // Control port pad pulls
      logic [7:0]         drv;    // Control pad drive
      logic [7:0]         cur_l;  // Left attenuation now applied
      logic [7:0]         cur_r;  // Right attenuation now applied
      logic [15:0]        tick;   // Cycles to next attenuation step
      logic [7:0]         rdata;  // Read data
      logic [W-1:0]       ol;     // Left sample out
      logic [W-1:0]       orr;    // Right sample out
      logic               ov;     // Sample out valid
   } state_s;

   state_s st_q;
   state_s st_d;

   // ==========================================================
   // Helpers
   // Negate with clamp; the most negative code has no positive twin
   function automatic logic [W-1:0] neg_sat(input logic [W-1:0] x);
      logic [W-1:0] mn;
      mn = {1'b1, {(W-1){1'b0}}};
      neg_sat = (x == mn) ? ~mn : (~x + {{(W-1){1'b0}}, 1'b1});
   endfunction : neg_sat
   // Mean of two samples, one bit wider so the sum cannot wrap
   function automatic logic [W-1:0] mix(input logic [W-1:0] a,
                                        input logic [W-1:0] b);
      logic [W:0] s;
      s   = {a[W-1], a} + {b[W-1], b};
      mix = s[W:1];
   endfunction : mix
   // Step a current code one toward its target
   function automatic logic [7:0] step(input logic [7:0] cur,
                                       input logic [7:0] tgt);
      if (cur < tgt) begin
         step = cur + 8'h01;
      end else if (cur > tgt) begin
         step = cur - 8'h01;
      end else begin
         step = cur;
      end
   endfunction : step
   // Pull decode: code 01 is reserved and acts as no resistor
   function automatic logic [3:0] pulls(input logic [7:0] r,
                                        input logic [1:0] code);
      logic [3:0] v;
      v = 4'h0;
      for (int i = 0; i < 4; i++) begin
         v[i] = (r[2*i +: 2] == code);
      end
      pulls = v;
   endfunction : pulls

   // ==========================================================
   // Next state
   always_comb begin
      logic [1:0]   mono;
      logic [W-1:0] l;
      logic [W-1:0] r;
      logic [W-1:0] m;
      st_d = st_q;
      mono = st_q.dac[playback_regs_pkg::MONO_LSB +: 2];
      l    = play_l_i;
      r    = play_r_i;
      m    = mix(play_l_i, play_r_i);
      // Register writes; reserved bits keep zero
      if (reg_wr_i) begin
         unique case (reg_addr_i)
            playback_regs_pkg::POP_OFS: begin
               st_d.pop = reg_wdata_i & playback_regs_pkg::POP_WMASK;
            end
            playback_regs_pkg::PWR_OFS: begin
               st_d.pwr = reg_wdata_i;
               // Reserved path bias code leaves the old choice
               if (reg_wdata_i[playback_regs_pkg::PPB_LSB +: 2] ==
                   playback_regs_pkg::PLAYBACK_PATH_BIAS_SEL_RSVD) begin
                  st_d.pwr[playback_regs_pkg::PPB_LSB +: 2] =
                     st_q.pwr[playback_regs_pkg::PPB_LSB +: 2];
               end
            end
            playback_regs_pkg::DAC_OFS: begin
               st_d.dac = reg_wdata_i & playback_regs_pkg::DAC_WMASK;
            end
            playback_regs_pkg::ATTL_OFS: st_d.att_l = reg_wdata_i;
            playback_regs_pkg::ATTR_OFS: st_d.att_r = reg_wdata_i;
            playback_regs_pkg::SPAD_OFS: st_d.spad  = reg_wdata_i;
            playback_regs_pkg::CPAD_OFS: st_d.cpad  = reg_wdata_i;
            playback_regs_pkg::DRV_OFS: begin
               st_d.drv = reg_wdata_i & playback_regs_pkg::DRV_WMASK;
            end
            default: ; // Unmapped offsets are ignored
         endcase
      end
      // Register reads; unmapped offsets answer zero
      if (reg_rd_i) begin
         unique case (reg_addr_i)
            playback_regs_pkg::POP_OFS:  st_d.rdata = st_q.pop;
            playback_regs_pkg::PWR_OFS:  st_d.rdata = st_q.pwr;
            playback_regs_pkg::DAC_OFS:  st_d.rdata = st_q.dac;
            playback_regs_pkg::ATTL_OFS: st_d.rdata = st_q.att_l;
            playback_regs_pkg::ATTR_OFS: st_d.rdata = st_q.att_r;
            playback_regs_pkg::SPAD_OFS: st_d.rdata = st_q.spad;
            playback_regs_pkg::CPAD_OFS: st_d.rdata = st_q.cpad;
            playback_regs_pkg::DRV_OFS:  st_d.rdata = st_q.drv;
            default:                     st_d.rdata = 8'h00;
         endcase
      end
      // Attenuation slews one step per interval, never jumps
      if (st_q.tick != 16'h0000) begin
         st_d.tick = st_q.tick - 16'h0001;
      end else if (st_q.cur_l != st_q.att_l ||
                   st_q.cur_r != st_q.att_r) begin
         st_d.cur_l = step(st_q.cur_l, st_q.att_l);
         st_d.cur_r = step(st_q.cur_r, st_q.att_r);
         st_d.tick  = 16'(ATT_STEP - 1);
      end
      // Sample path: mono mix, polarity, then channel enable
      st_d.ov = play_valid_i;
      if (play_valid_i) begin
         if (mono[0]) begin
            l = m;
         end
         if (mono[1]) begin
            r = m;
         end
         if (st_q.dac[playback_regs_pkg::POL_BIT]) begin
            l = neg_sat(l);
            r = neg_sat(r);
         end
         st_d.ol  = left_dac_on_o  ? l : '0;
         st_d.orr = right_dac_on_o ? r : '0;
      end
   end

   // ==========================================================
   // State register; clock enable freezes everything
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         st_q       <= '0;
         st_q.pop   <= playback_regs_pkg::POP_RST;
         st_q.pwr   <= playback_regs_pkg::PWR_RST;
         st_q.dac   <= playback_regs_pkg::DAC_RST;
         st_q.att_l <= playback_regs_pkg::ATT_RST;
         st_q.att_r <= playback_regs_pkg::ATT_RST;
         st_q.cur_l <= playback_regs_pkg::ATT_RST;
         st_q.cur_r <= playback_regs_pkg::ATT_RST;
         st_q.spad  <= playback_regs_pkg::PAD_RST;
         st_q.cpad  <= playback_regs_pkg::PAD_RST;
         st_q.drv   <= playback_regs_pkg::DRV_RST;
      end else if (ce_i) begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Decoded outputs
   logic [1:0] slew_sel; // Analog slew code
   assign slew_sel = st_q.pop[playback_regs_pkg::SLEW_LSB +: 2];
   // Ramp length in cycles; the analog stage does the ramping
   always_comb begin
      unique case (slew_sel)
         2'h0:    analog_ramp_cycles_o = 32'(SLEW0_CYCLES);
         2'h1:    analog_ramp_cycles_o = 32'(SLEW1_CYCLES);
         2'h2:    analog_ramp_cycles_o = 32'(SLEW2_CYCLES);
         default: analog_ramp_cycles_o = 32'h0000_0000;
      endcase
   end
   assign analog_slew_off_o = (slew_sel == playback_regs_pkg::SLEW_OFF);
   assign pop_suppress_active_o =
      !st_q.pop[playback_regs_pkg::POP_DIS_BIT];
   assign headphone_bias_sel_o =
      st_q.pwr[playback_regs_pkg::HPB_LSB +: 2];
   assign converter_bias_sel_o =
      st_q.pwr[playback_regs_pkg::CVB_LSB +: 2];
   assign playback_path_bias_sel_o =
      st_q.pwr[playback_regs_pkg::PPB_LSB +: 2];
   assign right_play_enable_o =
      st_q.pwr[playback_regs_pkg::REN_BIT];
   assign left_play_enable_o =
      st_q.pwr[playback_regs_pkg::LEN_BIT];
   assign left_dac_on_o   = st_q.dac[playback_regs_pkg::CEN_LSB];
   assign right_dac_on_o  = st_q.dac[playback_regs_pkg::CEN_LSB + 1];
   assign mono_on_left_o  = st_q.dac[playback_regs_pkg::MONO_LSB];
   assign mono_on_right_o = st_q.dac[playback_regs_pkg::MONO_LSB + 1];
   // Filter is only correct at 44.1 kHz; the host must see to that
   assign deemphasis_enable_o =
      st_q.dac[playback_regs_pkg::DEEMPHASIS_ENABLE_BIT];
   assign left_digital_attenuation_o  = st_q.cur_l;
   assign right_digital_attenuation_o = st_q.cur_r;
   assign audio_pad_pull_up_o   =
      pulls(st_q.spad, playback_regs_pkg::PULL_UP);
   assign audio_pad_pull_down_o =
      pulls(st_q.spad, playback_regs_pkg::PULL_DN);
   assign ctrl_pad_pull_up_o    =
      pulls(st_q.cpad, playback_regs_pkg::PULL_UP);
   assign ctrl_pad_pull_down_o  =
      pulls(st_q.cpad, playback_regs_pkg::PULL_DN);
   assign ctrl_data_out_drive_high_o =
      st_q.drv[playback_regs_pkg::DRV_BIT];
   assign reg_rdata_o = st_q.rdata;
   assign out_l_o     = st_q.ol;
   assign out_r_o     = st_q.orr;
   assign out_valid_o = st_q.ov;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   sequence s_wr(logic [15:0] ofs);
      ce_i && reg_wr_i && reg_addr_i == ofs;
   endsequence
   sequence s_rd(logic [15:0] ofs);
      ce_i && reg_rd_i && reg_addr_i == ofs;
   endsequence
   a_pop_disable: assert property (
      s_wr(playback_regs_pkg::POP_OFS) |=>
         pop_suppress_active_o == !$past(reg_wdata_i[3]))
      else $error("pop suppression does not follow write");
   a_slew_code: assert property (
      s_wr(playback_regs_pkg::POP_OFS) |=>
         analog_slew_off_o == ($past(reg_wdata_i[2:1]) == 2'h3) &&
         (analog_ramp_cycles_o == 32'h0) == analog_slew_off_o)
      else $error("slew off code not decoded");
   a_playback_path_bias_sel_reserved: assert property (
      s_wr(playback_regs_pkg::PWR_OFS) ##0 reg_wdata_i[3:2] == 2'h1 |=>
         $stable(playback_path_bias_sel_o))
      else $error("reserved path bias code was stored");
   a_chan_enable: assert property (
      s_wr(playback_regs_pkg::PWR_OFS) |=>
         right_play_enable_o == $past(reg_wdata_i[1]) &&
         left_play_enable_o  == $past(reg_wdata_i[0]))
      else $error("channel enables do not follow write");
   a_dac_off_zero: assert property (
      ce_i && play_valid_i && !left_dac_on_o && !right_dac_on_o |=>
         out_valid_o && out_l_o == '0 && out_r_o == '0)
      else $error("disabled converter passed data");
   a_pol_invert: assert property (
      ce_i && play_valid_i && left_dac_on_o && !mono_on_left_o &&
      st_q.dac[5] && play_l_i[W-1] == 1'b0 |=>
         out_l_o == ~$past(play_l_i) + 1'b1)
      else $error("left sample not inverted");
   a_deemph_bit: assert property (
      s_wr(playback_regs_pkg::DAC_OFS) |=>
         deemphasis_enable_o == $past(reg_wdata_i[2]))
      else $error("de-emphasis enable not stored");
   a_att_slew: assert property (
      ce_i && st_q.tick == 16'h0 && st_q.cur_l < st_q.att_l |=>
         left_digital_attenuation_o == $past(st_q.cur_l) + 8'h01)
      else $error("attenuation did not take one step");
   a_pad_decode: assert property (
      s_wr(playback_regs_pkg::SPAD_OFS) |=> audio_pad_pull_up_o[3] ==
         ($past(reg_wdata_i[7:6]) == 2'h0))
      else $error("audio pad pull not decoded");
   a_ctrl_pad: assert property (
      s_wr(playback_regs_pkg::CPAD_OFS) |=> ctrl_pad_pull_down_o[0] ==
         ($past(reg_wdata_i[1:0]) == 2'h3))
      else $error("control pad pull not decoded");
   a_drive_bit: assert property (
      s_wr(playback_regs_pkg::DRV_OFS) |=>
         ctrl_data_out_drive_high_o == $past(reg_wdata_i[0]))
      else $error("drive strength not stored");
   a_rsvd_zero: assert property (
      s_rd(playback_regs_pkg::DAC_OFS) |=> reg_rdata_o[4:3] == 2'h0)
      else $error("reserved bits read nonzero");

endmodule : playback_dac_pad_control_regs

// *** host_ctrl_model.sv ***
`timescale 1ns/10ps

// ==========================================================
// Host controller on the register port
module host_ctrl_model #(
   parameter int RATE_HZ = 44100 // Sampling rate the host runs at
) (
   // Clock
   input  wire logic        clk_i,
   // Register port
   output logic      [15:0] reg_addr_o,
   output logic             reg_wr_o,
   output logic      [7:0]  reg_wdata_o,
   output logic             reg_rd_o,
   input  wire logic [7:0]  reg_rdata_i
);
   // Idle port at time zero
   initial begin
      reg_addr_o  = 16'h0000;
      reg_wr_o    = 1'b0;
      reg_wdata_o = 8'h00;
      reg_rd_o    = 1'b0;
   end

   // Polite data: reserved places zero, filter only at 44.1 kHz
   function automatic logic [7:0] tidy(input logic [15:0] a,
                                       input logic [7:0]  d);
      logic [7:0] t;
      t = d;
      if (a == playback_regs_pkg::POP_OFS) t = t & 8'h1e;
      if (a == playback_regs_pkg::DAC_OFS) t = t & 8'he7;
      if (a == playback_regs_pkg::DRV_OFS) t = t & 8'h01;
      if (a == playback_regs_pkg::PWR_OFS && t[3:2] == 2'h1) begin
         t[3:2] = 2'h0;
      end
      if (a == playback_regs_pkg::DAC_OFS && RATE_HZ != 44100) begin
         t[2] = 1'b0;
      end
      return t;
   endfunction : tidy

   // One write; rude skips the tidying so refusals can be tried
   task automatic wr_reg(input logic [15:0] a, input logic [7:0] d,
                         input bit rude, output logic [7:0] sent);
      sent = rude ? d : tidy(a, d);
      @(posedge clk_i);
      reg_addr_o  <= a;
      reg_wdata_o <= sent;
      reg_wr_o    <= 1'b1;
      @(posedge clk_i);
      // Released lines show the inverse so stale data cannot pass
      reg_wr_o    <= 1'b0;
      reg_addr_o  <= ~a;
      reg_wdata_o <= ~sent;
   endtask : wr_reg

   // One read; data is taken one edge after the strobe is taken
   task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk_i);
      reg_addr_o <= a;
      reg_rd_o   <= 1'b1;
      @(posedge clk_i);
      reg_rd_o   <= 1'b0;
      reg_addr_o <= ~a;
      @(posedge clk_i);
      d = reg_rdata_i;
   endtask : rd_reg
endmodule : host_ctrl_model

// *** playback_dac_pad_control_regs_tb.sv ***
`timescale 1ns/10ps

// ==========================================================
// Bench for the playback register bank
module playback_dac_pad_control_regs_tb;
   logic        clk_i, nrst_i, ce_i;          // Clock, reset, enable
   logic [15:0] ra;                           // Register address
   logic        rw, rr;                       // Write and read strobes
   logic [7:0]  wd, rd;                       // Register data
   logic [23:0] pl, pr, ol, orr;              // Samples in and out
   logic        pv, ov;                       // Sample valids
   logic        pop, soff, ren, len, ldac, rdac, mol, mor, dem, drv;
   logic [31:0] ramp;                         // Ramp length
   logic [1:0]  hpb, cvb, ppb;                // Bias codes
   logic [7:0]  al, ar, pal, par;             // Attenuation, last seen
   logic [3:0]  apu, apd, cpu, cpd;           // Pad pulls
   logic [7:0]  m [9];                        // Register model
   logic [47:0] q [$];                        // Expected samples
   int          n_mismatch, compares, cyc, seed;
   localparam logic [15:0] OFS [9] = '{16'h4028, 16'h4029, 16'h402a,
      16'h402b, 16'h402c, 16'h402d, 16'h402f, 16'h4030, 16'h402e};
   localparam int RAMP [4] = '{40, 80, 160, 0}; // Shortened slews

   // ==========================================================
   // Design and host
   playback_dac_pad_control_regs #(.W(24), .SLEW0_CYCLES(40),
      .SLEW1_CYCLES(80), .SLEW2_CYCLES(160), .ATT_STEP(2)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .reg_addr_i(ra),
      .reg_wr_i(rw), .reg_wdata_i(wd), .reg_rd_i(rr), .reg_rdata_o(rd),
      .play_l_i(pl), .play_r_i(pr), .play_valid_i(pv), .out_l_o(ol),
      .out_r_o(orr), .out_valid_o(ov), .pop_suppress_active_o(pop),
      .analog_slew_off_o(soff), .analog_ramp_cycles_o(ramp),
      .headphone_bias_sel_o(hpb), .converter_bias_sel_o(cvb),
      .playback_path_bias_sel_o(ppb), .right_play_enable_o(ren),
      .left_play_enable_o(len), .left_dac_on_o(ldac),
      .right_dac_on_o(rdac), .mono_on_left_o(mol),
      .mono_on_right_o(mor), .deemphasis_enable_o(dem),
      .left_digital_attenuation_o(al), .right_digital_attenuation_o(ar),
      .audio_pad_pull_up_o(apu), .audio_pad_pull_down_o(apd),
      .ctrl_pad_pull_up_o(cpu), .ctrl_pad_pull_down_o(cpd),
      .ctrl_data_out_drive_high_o(drv));
   host_ctrl_model host (.clk_i(clk_i), .reg_addr_o(ra), .reg_wr_o(rw),
      .reg_wdata_o(wd), .reg_rd_o(rr), .reg_rdata_i(rd));

   // ==========================================================
   // Compares and verdict
   task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_reg
   task automatic cmp_ctl(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_ctl
   task automatic cmp_smp(input logic [47:0] g, input logic [47:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : cmp_smp
   task automatic give_verdict;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Model of the register bank
   task automatic put(input int i, input logic [7:0] d, input bit rude);
      logic [7:0] s;
      host.wr_reg(OFS[i], d, rude, s);
      case (i)
         0: m[0] = s & 8'h1e;
         1: m[1] = (s[3:2] == 2'h1) ? {s[7:4], m[1][3:2], s[1:0]} : s;
         2: m[2] = s & 8'he7;
         7: m[7] = s & 8'h01;
         8: m[8] = 8'h00; // Unmapped: nothing stored
         default: m[i] = s;
      endcase
   endtask : put
   task automatic chk_regs;
      logic [7:0] d;
      for (int i = 0; i < 9; i++) begin
         host.rd_reg(OFS[i], d);
         cmp_reg(d, m[i]);
      end
   endtask : chk_regs
   task automatic chk_ctl;
      logic [3:0] eu, ed, fu, fd;
      for (int k = 0; k < 4; k++) begin
         eu[k] = m[5][2*k+:2] == 2'h0;
         ed[k] = m[5][2*k+:2] == 2'h3;
         fu[k] = m[6][2*k+:2] == 2'h0;
         fd[k] = m[6][2*k+:2] == 2'h3;
      end
      cmp_ctl(32'(pop), 32'(!m[0][3]));
      cmp_ctl(32'(soff), 32'(m[0][2:1] == 2'h3));
      cmp_ctl(ramp, RAMP[m[0][2:1]]);
      cmp_ctl(32'({hpb, cvb, ppb}), 32'(m[1][7:2]));
      cmp_ctl(32'({ren, len}), 32'(m[1][1:0]));
      cmp_ctl(32'({mor,mol,rdac,ldac}), 32'({m[2][7:6],m[2][1:0]}));
      cmp_ctl(32'(dem), 32'(m[2][2]));
      cmp_ctl(32'({apu, apd}), 32'({eu, ed}));
      cmp_ctl(32'({cpu, cpd}), 32'({fu, fd}));
      cmp_ctl(32'(drv), 32'(m[7][0]));
   endtask : chk_ctl
   // Wait bounded for the slewed codes to reach their targets
   task automatic settle;
      for (int k = 0; k < 600 && (al !== m[3] || ar !== m[4]); k++)
         @(posedge clk_i);
      cmp_ctl(32'({al, ar}), 32'({m[3], m[4]}));
   endtask : settle
   // Clock enable low must freeze the slew part way through
   task automatic freeze;
      logic [15:0] v;
      @(posedge clk_i);
      ce_i <= 1'b0;
      @(posedge clk_i);
      v = {al, ar};
      repeat (4) @(posedge clk_i);
      cmp_ctl(32'({al, ar}), 32'(v));
      ce_i <= 1'b1;
   endtask : freeze

   // ==========================================================
   // Sample path: mix, then polarity with clamp, then enable
   function automatic logic [23:0] chan(input logic [23:0] a,
      input logic [23:0] b, input logic mix, input logic en);
      int v;
      v = mix ? ($signed(a) + $signed(b)) >>> 1 : $signed(a);
      if (m[2][5]) v = (v == -8388608) ? 8388607 : -v;
      return en ? v[23:0] : 24'h0;
   endfunction : chan
   // Back-to-back burst; left opens at the most negative value
   task automatic send(input int n);
      logic [23:0] l, r;
      for (int j = 0; j < n; j++) begin
         @(posedge clk_i);
         l = (j == 0) ? 24'h800000 : 24'($random(seed));
         r = 24'($random(seed));
         pl <= l;
         pr <= r;
         pv <= 1'b1;
         q.push_back({chan(l, r, m[2][6], m[2][0]),
                      chan(r, l, m[2][7], m[2][1])});
      end
      @(posedge clk_i);
      pv <= 1'b0;
      pl <= ~l;
      pr <= ~r;
      for (int k = 0; k < 8 && q.size() > 0; k++) @(posedge clk_i);
      cmp_ctl(32'(q.size()), 32'h0);
   endtask : send

   // One result per taken sample
   always @(posedge clk_i) begin
      if (ov === 1'b1) begin
         if (q.size() > 0) cmp_smp({ol, orr}, q.pop_front());
         else cmp_smp(48'h1, 48'h0);
      end
   end
   // Slewed codes move one step at a time
   always @(posedge clk_i) begin
      pal <= al;
      par <= ar;
      if (nrst_i === 1'b1 && al !== pal)
         cmp_ctl(32'(al - pal == 8'h01 || al - pal == 8'hff), 32'h1);
      if (nrst_i === 1'b1 && ar !== par)
         cmp_ctl(32'(ar - par == 8'h01 || ar - par == 8'hff), 32'h1);
   end
   // Clock and hang guard
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 60000) begin
         n_mismatch++;
         give_verdict;
      end
   end

   // ==========================================================
   // Main sequence
   initial begin
      seed = 78071;
      nrst_i = 1'b0;
      ce_i = 1'b1;
      pl = 24'h0;
      pr = 24'h0;
      pv = 1'b0;
      m = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'haa, 8'haa, 8'h00, 8'h00};
      repeat (20) @(posedge clk_i);
      nrst_i <= 1'b1;
      chk_regs;
      chk_ctl;
      // Every bit and two-bit field takes every code, reserved ones included; attenuation takes four
      for (int k = 0; k < 4; k++) begin
         for (int i = 0; i < 9; i++) put(i, 8'(8'h55 * k), 1'b1);
         freeze;
         settle;
         chk_regs;
         chk_ctl;
         send(6);
      end
      // Random traffic, polite and rude in turn
      for (int t = 0; t < 30; t++) begin
         put({$random(seed)} % 9, 8'($random(seed)), t[0]);
         freeze;
         settle;
         chk_regs;
         chk_ctl;
         send(4);
      end
      give_verdict;
   end
endmodule : playback_dac_pad_control_regs_tb
